// ---- sbst_pkg.sv ----
// Shared constants for the memory test port, and its two-flop synchroniser.
`default_nettype none
package sbst_pkg;
    localparam int IR_W = 3;
    localparam int BSR_W = 75;
    localparam int ID_W = 32;
    localparam int TMS_RESET_EDGES = 5;
    // Pattern loaded into the two low instruction bits on capture.
    localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
    // Default instruction codes; the top module exposes them as parameters.
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
    // Identity word; the value is arbitrary.
    localparam logic [ID_W-1:0] ID_WORD_DEF = 32'h0000_0001;
    localparam logic BYPASS_CLEAR = 1'h0;
    // Test controller states, one-hot.
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008,
        ST_SHDR = 16'h0010,
        ST_EX1DR = 16'h0020,
        ST_PADR = 16'h0040,
        ST_EX2DR = 16'h0080,
        ST_UPDR = 16'h0100,
        ST_SELIR = 16'h0200,
        ST_CAPIR = 16'h0400,
        ST_SHIR = 16'h0800,
        ST_EX1IR = 16'h1000,
        ST_PAIR = 16'h2000,
        ST_EX2IR = 16'h4000,
        ST_UPIR = 16'h8000
    } sbst_state_t;
endpackage
`default_nettype wire

// Two-flop synchroniser; with d tied high it also releases a reset.
`default_nettype none
module sbst_sync #(
    parameter int W = 1
) (
    input wire logic clk, // Destination clock.
    input wire logic rst_n, // Asynchronous clear, active low.
    input wire logic [W-1:0] d, // Level from another domain.
    output logic [W-1:0] q // Synchronised level.
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // First stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// ---- sbst_tap.sv ----
// Boundary-scan test access port of the synchronous memory.
`default_nettype none
// What this block does
// [RULE1] Inputs taken on rising test clock, outputs on falling.
// [RULE2] State steps on mode select each rising edge; open line is high.
// [RULE3] Serial data enters the top bit of the selected register.
// [RULE4] Serial out is the selected bottom bit, changed on falling edge.
// [RULE5] Data-out driver on only in the shift states, else floating.
// [RULE6] Five rising edges with mode select high reset the test logic only.
// [RULE7] Power-up resets the controller; data out starts floating.
// [RULE8] One data register at a time, chosen by the held instruction.
// [RULE9] Three-bit instruction holds the identity code after any reset.
// [RULE10] Instruction capture loads 01 into the two low bits.
// [RULE11] Bypass is one flip-flop, cleared in data capture while bypass is selected.
// [RULE12] Boundary register is 75 cells, one per input or two-way ball.
// [RULE13] Data capture loads the ring; data shift connects the cells.
// [RULE14] External test, sample and sample-float all capture the ring.
// [RULE15] Identity instruction captures a fixed 32-bit word to shift out.
// [RULE16] All-zero instruction acts as sample but floats memory outputs.
// [RULE17] Sample-float shifts boundary cells and floats memory outputs.
// [RULE18] Preload absent: data update under sample acts like data pause.
// [RULE19] The tester loads only the five defined instruction codes.
// [RULE20] Controller is the standard sixteen-state access state machine.
// [RULE21] Instruction codes and identity word are design parameters.
module sbst_tap #( // [RULE21]
    parameter logic [sbst_pkg::IR_W-1:0] P_EXTEST = sbst_pkg::INS_EXTEST,
    parameter logic [sbst_pkg::IR_W-1:0] P_IDCODE = sbst_pkg::INS_IDCODE,
    parameter logic [sbst_pkg::IR_W-1:0] P_SAMPLEZ = sbst_pkg::INS_SAMPLEZ,
    parameter logic [sbst_pkg::IR_W-1:0] P_SAMPLE = sbst_pkg::INS_SAMPLE,
    parameter logic [sbst_pkg::IR_W-1:0] P_BYPASS = sbst_pkg::INS_BYPASS,
    parameter logic [sbst_pkg::ID_W-1:0] P_ID_WORD = sbst_pkg::ID_WORD_DEF
) (
    input wire logic clk, // Memory clock, 20 MHz.
    input wire logic resetn, // Power-up reset, active low, asynchronous.
    input wire logic tck, // Test clock from the tester.
    input wire logic tms, // Mode select, pad pulls it high.
    input wire logic tdi, // Serial data in, pad pulls it high.
    output logic tdo, // Serial data out.
    output logic tdo_oe, // High while data out is driven.
    input wire logic [sbst_pkg::BSR_W-1:0] io_ring, // Ball levels of the ring.
    output logic mem_hiz // Forces memory outputs to high impedance.
);
    import sbst_pkg::*;

    logic rst_clk_n;
    logic rst_tck_n;
    logic [BSR_W-1:0] ring_s;
    logic hiz_s;
    sbst_state_t state_r, state_nxt;
    logic [IR_W-1:0] ir_r, ir_nxt;
    logic [IR_W-1:0] irsh_r, irsh_nxt;
    logic byp_r, byp_nxt;
    logic [ID_W-1:0] id_r, id_nxt;
    logic [BSR_W-1:0] bsr_r, bsr_nxt;
    logic hiz_r, hiz_nxt;
    logic tdo_r, tdo_nxt;
    logic oe_r, oe_nxt;
    logic sel_bsr, sel_id, sel_byp;

    // Reset release in each domain; power-up needs no test sequence.
    sbst_sync #(.W(1)) u_rst_clk (
        .clk(clk), .rst_n(resetn), .d(1'h1), .q(rst_clk_n)
    );
    sbst_sync #(.W(1)) u_rst_tck (
        .clk(tck), .rst_n(resetn), .d(1'h1), .q(rst_tck_n) // [RULE7]
    );

    // Ring levels move on the memory clock, so they are synchronised first.
    sbst_sync #(.W(BSR_W)) u_ring (
        .clk(tck), .rst_n(rst_tck_n), .d(io_ring), .q(ring_s)
    );

    // Float request crosses back into the memory clock domain.
    sbst_sync #(.W(1)) u_hiz (
        .clk(clk), .rst_n(rst_clk_n), .d(hiz_r), .q(hiz_s)
    );
    assign mem_hiz = hiz_s;

    // Data register selection from the held instruction; reserved codes bypass.
    always_comb begin
        sel_bsr = (ir_r == P_EXTEST) || (ir_r == P_SAMPLE) ||
                  (ir_r == P_SAMPLEZ); // [RULE8] [RULE14]
        sel_id = (ir_r == P_IDCODE);
        sel_byp = !sel_bsr && !sel_id;
    end

    // Controller next state from mode select.
    always_comb begin
        state_nxt = ST_TLR;
        unique case (state_r) // [RULE20] [RULE2]
            ST_TLR: state_nxt = tms ? ST_TLR : ST_RTI; // [RULE6]
            ST_RTI: state_nxt = tms ? ST_SELDR : ST_RTI;
            ST_SELDR: state_nxt = tms ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: state_nxt = tms ? ST_EX1DR : ST_SHDR;
            ST_SHDR: state_nxt = tms ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: state_nxt = tms ? ST_UPDR : ST_PADR;
            ST_PADR: state_nxt = tms ? ST_EX2DR : ST_PADR;
            ST_EX2DR: state_nxt = tms ? ST_UPDR : ST_SHDR;
            ST_UPDR: state_nxt = tms ? ST_SELDR : ST_RTI;
            ST_SELIR: state_nxt = tms ? ST_TLR : ST_CAPIR;
            ST_CAPIR: state_nxt = tms ? ST_EX1IR : ST_SHIR;
            ST_SHIR: state_nxt = tms ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: state_nxt = tms ? ST_UPIR : ST_PAIR;
            ST_PAIR: state_nxt = tms ? ST_EX2IR : ST_PAIR;
            ST_EX2IR: state_nxt = tms ? ST_UPIR : ST_SHIR;
            ST_UPIR: state_nxt = tms ? ST_SELDR : ST_RTI;
            default: state_nxt = ST_TLR;
        endcase
    end

    // Instruction path: capture pattern, shift from the top, update, reset.
    always_comb begin
        irsh_nxt = irsh_r;
        ir_nxt = ir_r;
        if (state_r == ST_CAPIR) begin
            irsh_nxt = {ir_r[IR_W-1], IR_CAPTURE_PAT}; // [RULE10]
        end else if (state_r == ST_SHIR) begin
            irsh_nxt = {tdi, irsh_r[IR_W-1:1]}; // [RULE3]
        end
        if (state_r == ST_TLR) begin
            ir_nxt = P_IDCODE; // [RULE9]
        end else if (state_r == ST_UPIR) begin
            ir_nxt = irsh_r; // [RULE8]
        end
        // Memory outputs float under the all-zero and sample-float codes.
        hiz_nxt = (ir_r == P_EXTEST) ||
                  (ir_r == P_SAMPLEZ); // [RULE16] [RULE17]
    end

    // Data registers: capture in data capture, shift in data shift.
    always_comb begin
        byp_nxt = byp_r;
        id_nxt = id_r;
        bsr_nxt = bsr_r;
        if (state_r == ST_CAPDR) begin
            if (sel_byp) begin
                byp_nxt = BYPASS_CLEAR; // [RULE11]
            end
            if (sel_id) begin
                id_nxt = P_ID_WORD; // [RULE15]
            end
            if (sel_bsr) begin
                bsr_nxt = ring_s; // [RULE13] [RULE14]
            end
        end else if (state_r == ST_SHDR) begin
            if (sel_byp) begin
                byp_nxt = tdi;
            end
            if (sel_id) begin
                id_nxt = {tdi, id_r[ID_W-1:1]}; // [RULE3]
            end
            if (sel_bsr) begin
                bsr_nxt = {tdi, bsr_r[BSR_W-1:1]}; // [RULE3] [RULE12]
            end
        end
        // Data update loads nothing, as preload is absent.  [RULE18]
    end

    // Rising-edge state of the test logic.
    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            state_r <= ST_TLR;
            ir_r <= P_IDCODE; // [RULE9]
            irsh_r <= '0;
            byp_r <= BYPASS_CLEAR;
            id_r <= '0;
            bsr_r <= '0;
            hiz_r <= 1'h0;
        end else begin
            state_r <= state_nxt; // [RULE1]
            ir_r <= ir_nxt;
            irsh_r <= irsh_nxt;
            byp_r <= byp_nxt;
            id_r <= id_nxt;
            bsr_r <= bsr_nxt;
            hiz_r <= hiz_nxt;
        end
    end

    // Serial output value and its driver enable for the falling edge.
    always_comb begin
        tdo_nxt = 1'h0;
        oe_nxt = 1'h0;
        if (state_r == ST_SHIR) begin
            tdo_nxt = irsh_r[0]; // [RULE4]
            oe_nxt = 1'h1; // [RULE5]
        end else if (state_r == ST_SHDR) begin
            oe_nxt = 1'h1;
            if (sel_bsr) begin
                tdo_nxt = bsr_r[0];
            end else if (sel_id) begin
                tdo_nxt = id_r[0];
            end else begin
                tdo_nxt = byp_r;
            end
        end
    end

    // Data out changes only on the falling test clock edge.
    always_ff @(negedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            tdo_r <= 1'h0;
            oe_r <= 1'h0; // [RULE7]
        end else begin
            tdo_r <= tdo_nxt; // [RULE1] [RULE4]
            oe_r <= oe_nxt;
        end
    end

    assign tdo = tdo_r;
    assign tdo_oe = oe_r;

    // Checks on the test clock domain.
    sequence s_tms_high_run;
        tms [*5];
    endsequence

    sequence s_capture_id;
        (state_r == ST_CAPDR) && sel_id;
    endsequence

    property p_tms_reset;
        @(posedge tck) disable iff (!rst_tck_n)
        s_tms_high_run |=> (state_r == ST_TLR);
    endproperty
    a_tms_reset: assert property (p_tms_reset) // [RULE6]
        else $error("Five high mode-select edges did not reset.");

    property p_ir_reset;
        @(posedge tck) disable iff (!rst_tck_n)
        (state_r == ST_TLR) |=> (ir_r == P_IDCODE);
    endproperty
    a_ir_reset: assert property (p_ir_reset) // [RULE9]
        else $error("Instruction not identity after reset state.");

    property p_ir_capture;
        @(posedge tck) disable iff (!rst_tck_n)
        (state_r == ST_CAPIR) |=> (irsh_r[1:0] == IR_CAPTURE_PAT);
    endproperty
    a_ir_capture: assert property (p_ir_capture) // [RULE10]
        else $error("Instruction capture pattern wrong.");

    property p_ir_update;
        @(posedge tck) disable iff (!rst_tck_n)
        (state_r == ST_UPIR) |=> (ir_r == $past(irsh_r));
    endproperty
    a_ir_update: assert property (p_ir_update) // [RULE8]
        else $error("Instruction not taken on update.");

    property p_id_capture;
        @(posedge tck) disable iff (!rst_tck_n)
        s_capture_id ##1 (state_r == ST_SHDR) |-> (tdo_r == P_ID_WORD[0]);
    endproperty
    a_id_capture: assert property (p_id_capture) // [RULE15]
        else $error("Identity word bit zero not on data out.");

    property p_bypass_clear;
        @(posedge tck) disable iff (!rst_tck_n)
        (state_r == ST_CAPDR) && sel_byp |=> (byp_r == BYPASS_CLEAR);
    endproperty
    a_bypass_clear: assert property (p_bypass_clear) // [RULE11]
        else $error("Bypass not cleared on capture.");

    property p_bsr_shift;
        @(posedge tck) disable iff (!rst_tck_n)
        (state_r == ST_SHDR) && sel_bsr |=> (bsr_r[BSR_W-1] == $past(tdi));
    endproperty
    a_bsr_shift: assert property (p_bsr_shift) // [RULE3]
        else $error("Serial data did not enter the top cell.");

    property p_oe_state;
        @(posedge tck) disable iff (!rst_tck_n)
        oe_r == ((state_r == ST_SHDR) || (state_r == ST_SHIR));
    endproperty
    a_oe_state: assert property (p_oe_state) // [RULE5]
        else $error("Data-out enable disagrees with state.");

    property p_tdo_bypass;
        @(posedge tck) disable iff (!rst_tck_n)
        (state_r == ST_SHDR) && sel_byp |-> (tdo_r == byp_r);
    endproperty
    a_tdo_bypass: assert property (p_tdo_bypass) // [RULE4]
        else $error("Data out is not the bypass bit.");

    property p_hiz;
        @(posedge tck) disable iff (!rst_tck_n)
        (ir_r == P_SAMPLEZ) ##1 (ir_r == P_SAMPLEZ) |-> hiz_r;
    endproperty
    a_hiz: assert property (p_hiz) // [RULE17]
        else $error("Memory outputs not floated under sample-float.");

    property p_extest_hiz;
        @(posedge tck) disable iff (!rst_tck_n)
        (ir_r == P_EXTEST) |=> hiz_r;
    endproperty
    a_extest_hiz: assert property (p_extest_hiz) // [RULE16]
        else $error("Memory outputs not floated under all-zero code.");

    property p_ring_capture;
        @(posedge tck) disable iff (!rst_tck_n)
        (state_r == ST_CAPDR) && sel_bsr |=> (bsr_r == $past(ring_s));
    endproperty
    a_ring_capture: assert property (p_ring_capture) // [RULE13]
        else $error("Boundary cells did not capture the ring.");

    property p_ir_tdo;
        @(posedge tck) disable iff (!rst_tck_n)
        (state_r == ST_SHIR) |-> (tdo_r == irsh_r[0]);
    endproperty
    a_ir_tdo: assert property (p_ir_tdo) // [RULE4]
        else $error("Data out is not the instruction bottom bit.");
endmodule
`default_nettype wire

// ---- sbst_tester.sv ----
// Board tester model that drives the test clock, mode select and data in.
`default_nettype none
module sbst_tester (
    output logic tck, // Test clock, still low between frames.
    output logic tms, // Mode select.
    output logic tdi, // Serial data towards the port.
    input wire logic tdo, // Serial data from the port.
    input wire logic tdo_oe // Driver enable of data out.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic oe_ok;
    // Released lines sit at their pull-up level.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        oe_ok = 1'b1;
    end
    // One 12 ns period: lines change while the clock is low, data out is
    // taken at the rising edge, which is when the port samples too.
    task automatic step(input logic m, input logic d, output logic q,
                        output logic e);
        tms = m;
        tdi = d;
        #6 tck = 1'b1;
        // A floating data out reads as the inverse of its driven level.
        q = tdo_oe ? tdo : !tdo;
        e = tdo_oe;
        #6 tck = 1'b0;
    endtask
    // Five rising edges with mode select high, then park in run-test-idle.
    task automatic tap_reset();
        logic q;
        logic e;
        repeat (5) step(1'b1, 1'b1, q, e);
        step(1'b0, 1'b1, q, e);
        // Release off the clock edge so no line is set twice at once.
        #3 tms = 1'b1;
    endtask
    // Full scan from run-test-idle back to run-test-idle, bit 0 first.
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic q;
        logic e;
        dout = '0;
        step(1'b1, 1'b1, q, e);
        if (ir) begin
            step(1'b1, 1'b1, q, e);
        end
        step(1'b0, 1'b1, q, e);
        step(1'b0, 1'b1, q, e);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q, e);
            dout[i] = q;
            if (e !== 1'b1) begin
                oe_ok = 1'b0;
            end
        end
        step(1'b1, 1'b1, q, e);
        step(1'b0, 1'b1, q, e);
        // Release off the clock edge so no line is set twice at once.
        #3 tms = 1'b1;
        tdi = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the memory test port.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sbst_pkg::*;
    localparam logic [74:0] RING = 75'h4a5_c3c3_0ff0_1234_abcd;
    logic clk;
    logic resetn;
    logic [74:0] io_ring;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic mem_hiz;
    int num_errors = 0;
    int checks = 0;
    sbst_tap u_dut (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .io_ring(io_ring),
        .mem_hiz(mem_hiz));
    sbst_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));
    // Memory clock at 20 MHz.
    always #25 clk = ~clk;
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // After power-up the identity word is reached without loading anything.
    task automatic t_powerup();
        logic [127:0] d;
        check(tdo_oe, 1'b0);
        check(mem_hiz, 1'b0);
        u_tst.scan(1'b0, 32, 128'h0, d);
        check(d[31:0], ID_WORD_DEF);
    endtask
    // Capture pattern on the instruction path, then a one-bit bypass path.
    task automatic t_bypass();
        logic [127:0] d;
        u_tst.scan(1'b1, 3, {125'h0, INS_BYPASS}, d);
        check(d[1:0], IR_CAPTURE_PAT);
        check(d[2], INS_IDCODE[2]);
        u_tst.scan(1'b0, 9, 128'h1b5, d);
        check(d[8:0], {8'hb5, 1'b0});
    endtask
    // Each ring instruction captures the balls; two scans each, since the
    // update after the first must not preload anything.
    task automatic t_ring();
        logic [127:0] d;
        logic [2:0] codes [3] = '{INS_EXTEST, INS_SAMPLE, INS_SAMPLEZ};
        logic hiz [3] = '{1'b1, 1'b0, 1'b1};
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            io_ring = RING ^ (75'h1 << (k * 20));
            u_tst.scan(1'b1, 3, {125'h0, codes[k]}, d);
            for (int j = 0; j < 2; j++) begin
                u_tst.scan(1'b0, 77, 128'h2, d);
                check(d[74:0], io_ring);
                check(d[76:75], 2'h2);
                repeat (4) @(negedge clk);
                check(mem_hiz, hiz[k]);
            end
        end
    endtask
    // Mode-select reset returns the identity instruction.
    task automatic t_tms_reset();
        logic [127:0] d;
        u_tst.scan(1'b1, 3, {125'h0, INS_BYPASS}, d);
        u_tst.tap_reset();
        u_tst.scan(1'b0, 32, 128'h0, d);
        check(d[31:0], ID_WORD_DEF);
        repeat (4) @(negedge clk);
        check(mem_hiz, 1'b0);
        check(tdo_oe, 1'b0);
        check(u_tst.oe_ok, 1'b1);
    endtask
    // Bound on the whole run.
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
    // Main sequence: power-up reset, then the scenarios.
    initial begin
        logic q;
        logic e;
        clk = 1'b0;
        resetn = 1'b0;
        io_ring = RING;
        repeat (2) u_tst.step(1'b1, 1'b1, q, e);
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (3) u_tst.step(1'b0, 1'b1, q, e);
        repeat (3) @(negedge clk);
        t_powerup();
        t_bypass();
        t_ring();
        t_tms_reset();
        end_sim();
    end
endmodule
`default_nettype wire
